// >>> rtl/pti_top.sv
`timescale 1ns/100ps
// Threshold and interrupt-status registers of a proximity sensor behind a two-wire bus.
module pti_top
  import pti_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h13, // Arbitrary bus address.
  parameter int CNT_W = 8
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic int_pad_out,
  output logic int_pad_oe,
  input wire pti_meas_t meas
);

  if (CNT_W < 8)
  begin : g_chk
    $error("pti_top: CNT_W must hold a run of 128");
  end

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ACK_ADDR = 9'h004,
    ST_PTR = 9'h008,
    ST_ACK_PTR = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_WR = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK = 9'h100
  } pti_state_t;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_f_reg;
  logic sda_f_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2])
      begin
        scl_f_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2])
      begin
        sda_f_reg <= sda_sync_reg[2];
      end
    end
  end

  logic scl_f_next;
  logic sda_f_next;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_comb
  begin
    scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
    sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
    scl_rise = scl_f_next & ~scl_f_reg;
    scl_fall = ~scl_f_next & scl_f_reg;
    bus_start = scl_f_reg & scl_f_next & sda_f_reg & ~sda_f_next;
    bus_stop = scl_f_reg & scl_f_next & ~sda_f_reg & sda_f_next;
  end

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [7:0] ctrl_reg;
  logic [15:0] low_thr_reg;
  logic [15:0] high_thr_reg;
  logic [7:0] mod_timing_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  pti_wr_t wr_reg;

  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] fl,
                                          input logic [7:0] ct, input logic [15:0] lo,
                                          input logic [15:0] hi, input logic [7:0] mt);
    logic [7:0] r;
    r = PTI_RD_UNMAPPED;
    unique case (a)
      PTI_OFS_INT_CTRL: r = ct;
      PTI_OFS_LOW_HI: r = lo[15:8];
      PTI_OFS_LOW_LO: r = lo[7:0];
      PTI_OFS_HIGH_HI: r = hi[15:8];
      PTI_OFS_HIGH_LO: r = hi[7:0];
      PTI_OFS_FLAGS: r = fl;
      PTI_OFS_MOD_TIMING: r = mt;
      default: r = PTI_RD_UNMAPPED;
    endcase
    return r;
  endfunction : reg_read

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_reg <= PTI_RST_INT_CTRL;
      low_thr_reg <= {PTI_RST_THRESH, PTI_RST_THRESH};
      high_thr_reg <= {PTI_RST_THRESH, PTI_RST_THRESH};
      mod_timing_reg <= PTI_RST_MOD_TIMING;
    end
    else if (wr_reg.en)
    begin
      unique case (wr_reg.addr)
        PTI_OFS_INT_CTRL: ctrl_reg <= wr_reg.data;
        PTI_OFS_LOW_HI: low_thr_reg[15:8] <= wr_reg.data;
        PTI_OFS_LOW_LO: low_thr_reg[7:0] <= wr_reg.data;
        PTI_OFS_HIGH_HI: high_thr_reg[15:8] <= wr_reg.data;
        PTI_OFS_HIGH_LO: high_thr_reg[7:0] <= wr_reg.data;
        PTI_OFS_MOD_TIMING: mod_timing_reg <= wr_reg.data;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Threshold detection and status flags
  // ==========================================================================
  logic thr_sample;
  logic below_hit;
  logic above_hit;

  assign thr_sample = meas.valid & ~ctrl_reg[PTI_CTRL_THRES_SEL];

  pti_persist #(
    .CNT_W(CNT_W)
  ) u_below (
    .clk(clk),
    .nrst(nrst),
    .sample(thr_sample),
    .beyond(meas.data < low_thr_reg),
    .code(ctrl_reg[PTI_CTRL_CNT_MSB:PTI_CTRL_CNT_LSB]),
    .hit(below_hit)
  );

  pti_persist #(
    .CNT_W(CNT_W)
  ) u_above (
    .clk(clk),
    .nrst(nrst),
    .sample(thr_sample),
    .beyond(meas.data > high_thr_reg),
    .code(ctrl_reg[PTI_CTRL_CNT_MSB:PTI_CTRL_CNT_LSB]),
    .hit(above_hit)
  );

  always_comb
  begin
    flags_next = flags_reg;
    if (wr_reg.en && wr_reg.addr == PTI_OFS_FLAGS)
    begin
      flags_next = flags_reg & ~wr_reg.data;
    end
    if (meas.valid && ctrl_reg[PTI_CTRL_READY_EN])
    begin
      flags_next[PTI_FLAG_READY] = 1'b1;
    end
    if (below_hit && ctrl_reg[PTI_CTRL_THRES_EN])
    begin
      flags_next[PTI_FLAG_BELOW] = 1'b1;
    end
    if (above_hit && ctrl_reg[PTI_CTRL_THRES_EN])
    begin
      flags_next[PTI_FLAG_ABOVE] = 1'b1;
    end
    flags_next[7:4] = 4'h0;
    flags_next[2] = 1'b0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flags_reg <= 8'h00;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  // ==========================================================================
  // Interrupt pad
  // ==========================================================================
  logic int_oe_reg;
  logic pad_low_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      int_oe_reg <= 1'b0;
      pad_low_reg <= 1'b0;
    end
    else
    begin
      int_oe_reg <= |flags_next;
      pad_low_reg <= 1'b0;
    end
  end

  assign int_pad_oe = int_oe_reg;
  assign int_pad_out = pad_low_reg;
  assign sda_out = pad_low_reg;

  // ==========================================================================
  // Two-wire bus slave
  // ==========================================================================
  pti_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic rnw_reg;
  logic nack_reg;
  logic sda_oe_reg;
  logic [7:0] rd_byte;

  assign rd_byte = reg_read(ptr_reg, flags_reg, ctrl_reg, low_thr_reg, high_thr_reg,
                            mod_timing_reg);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rnw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wr_reg <= '0;
    end
    else
    begin
      wr_reg.en <= 1'b0;
      if (bus_start)
      begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (state_reg == ST_RACK)
        begin
          nack_reg <= sda_f_reg;
        end
        else
        begin
          rx_reg <= {rx_reg[6:0], sda_f_reg};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end
      else if (scl_fall)
      begin
        unique case (state_reg)
          ST_IDLE: ;
          ST_ADDR:
            if (bit_cnt_reg == PTI_BITS_PER_BYTE)
            begin
              bit_cnt_reg <= 4'h0;
              if (rx_reg[7:1] == DEV_ADDR)
              begin
                rnw_reg <= rx_reg[0];
                sda_oe_reg <= 1'b1;
                state_reg <= ST_ACK_ADDR;
              end
              else
              begin
                state_reg <= ST_IDLE;
              end
            end
          ST_ACK_ADDR:
          begin
            bit_cnt_reg <= 4'h0;
            if (rnw_reg)
            begin
              tx_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_RDATA;
            end
            else
            begin
              sda_oe_reg <= 1'b0;
              state_reg <= ST_PTR;
            end
          end
          ST_PTR:
            if (bit_cnt_reg == PTI_BITS_PER_BYTE)
            begin
              ptr_reg <= rx_reg;
              sda_oe_reg <= 1'b1;
              state_reg <= ST_ACK_PTR;
            end
          ST_WDATA:
            if (bit_cnt_reg == PTI_BITS_PER_BYTE)
            begin
              wr_reg.en <= 1'b1;
              wr_reg.addr <= ptr_reg;
              wr_reg.data <= rx_reg;
              ptr_reg <= ptr_reg + 8'h01;
              sda_oe_reg <= 1'b1;
              state_reg <= ST_ACK_WR;
            end
          ST_ACK_PTR, ST_ACK_WR:
          begin
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
            state_reg <= ST_WDATA;
          end
          ST_RDATA:
            if (bit_cnt_reg == PTI_BITS_PER_BYTE)
            begin
              sda_oe_reg <= 1'b0;
              state_reg <= ST_RACK;
            end
            else
            begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
            end
          ST_RACK:
          begin
            bit_cnt_reg <= 4'h0;
            if (nack_reg)
            begin
              state_reg <= ST_IDLE;
            end
            else
            begin
              tx_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= ST_RDATA;
            end
          end
        endcase
      end
    end
  end

  assign sda_oe = sda_oe_reg;

endmodule : pti_top

// >>> common/pti_pkg.sv
// Function
// - Low threshold is 16 bits, upper byte at 0x8A, lower byte at 0x8B.
// - High threshold is 16 bits, upper byte at 0x8C, lower byte at 0x8D.
// - Status at 0x8E has a flag set on each data-ready interrupt.
// - Below-limit flag sets when a measurement falls under the low threshold.
// - Above-limit flag sets when a measurement rises over the high threshold.
// - A set flag stays one until the host writes a one to its bit.
// - Interrupt pad is pulled low while any status flag is one.
// - Threshold flags need 1,2,4..128 consecutive crossings, chosen by a 3-bit code.
// - Threshold flags set only while the threshold interrupt enable is one.
package pti_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] PTI_OFS_INT_CTRL = 8'h89;
  localparam logic [7:0] PTI_OFS_LOW_HI = 8'h8a;
  localparam logic [7:0] PTI_OFS_LOW_LO = 8'h8b;
  localparam logic [7:0] PTI_OFS_HIGH_HI = 8'h8c;
  localparam logic [7:0] PTI_OFS_HIGH_LO = 8'h8d;
  localparam logic [7:0] PTI_OFS_FLAGS = 8'h8e;
  localparam logic [7:0] PTI_OFS_MOD_TIMING = 8'h8f;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int PTI_CTRL_CNT_MSB = 7;
  localparam int PTI_CTRL_CNT_LSB = 5;
  localparam int PTI_CTRL_READY_EN = 3;
  localparam int PTI_CTRL_THRES_EN = 1;
  localparam int PTI_CTRL_THRES_SEL = 0;
  localparam int PTI_FLAG_READY = 3;
  localparam int PTI_FLAG_BELOW = 1;
  localparam int PTI_FLAG_ABOVE = 0;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] PTI_RST_INT_CTRL = 8'h00;
  localparam logic [7:0] PTI_RST_THRESH = 8'h00;
  localparam logic [7:0] PTI_RST_MOD_TIMING = 8'h00;
  localparam logic [7:0] PTI_RD_UNMAPPED = 8'h00;

  // ==========================================================================
  // Serial bus constants
  // ==========================================================================
  localparam logic [3:0] PTI_BITS_PER_BYTE = 4'h8;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } pti_meas_t;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } pti_wr_t;

endpackage : pti_pkg

// >>> rtl/pti_persist.sv
`timescale 1ns/100ps
// Counts consecutive crossing measurements and pulses once the programmed run is reached.
module pti_persist
  import pti_pkg::*;
#(
  parameter int CNT_W = 8
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sample,
  input wire logic beyond,
  input wire logic [2:0] code,
  output logic hit
);

  if (CNT_W < 8)
  begin : g_chk
    $error("pti_persist: CNT_W must hold a run of 128");
  end

  logic [CNT_W-1:0] run_reg;
  logic [CNT_W-1:0] run_next;
  logic [CNT_W-1:0] need;
  logic hit_reg;

  // ==========================================================================
  // Run length
  // ==========================================================================
  always_comb
  begin
    need = CNT_W'(1) << code;
    run_next = run_reg + CNT_W'(1);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      run_reg <= '0;
      hit_reg <= 1'b0;
    end
    else
    begin
      hit_reg <= 1'b0;
      if (sample)
      begin
        if (!beyond)
        begin
          run_reg <= '0;
        end
        else if (run_next >= need)
        begin
          run_reg <= '0;
          hit_reg <= 1'b1;
        end
        else
        begin
          run_reg <= run_next;
        end
      end
    end
  end

  assign hit = hit_reg;

endmodule : pti_persist

// >>> verification/pti_top_sva.sv
`timescale 1ns/100ps
// ==========================================================================
// Port checker
// ==========================================================================
module pti_top_sva
  import pti_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic int_pad_out,
  input wire logic int_pad_oe,
  input wire pti_meas_t meas
);
  logic [7:0] gap_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Cycles since the bus clock pin last fell, saturating at all ones.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      gap_reg <= 8'hff;
    else if ($fell(scl_in))
      gap_reg <= 8'h00;
    else if (gap_reg != 8'hff)
      gap_reg <= gap_reg + 8'h01;
  end

  sequence meas_recent_s;
    $past(meas.valid, 1) || $past(meas.valid, 2);
  endsequence

  sequence bus_quiet_s;
    int_pad_oe && gap_reg > 8'h0c;
  endsequence

  pad_level_a: assert property (int_pad_out == 1'b0)
    else $error("interrupt pad driven high");
  sda_level_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  reset_quiet_a: assert property ($rose(nrst) |-> !int_pad_oe && !sda_oe)
    else $error("pins driven right after reset");
  pad_rise_a: assert property ($rose(int_pad_oe) |-> meas_recent_s)
    else $error("interrupt raised without a measurement");
  pad_clear_a: assert property ($fell(int_pad_oe) |-> gap_reg <= 8'h0c)
    else $error("interrupt released without a bus write");
  pad_hold_a: assert property (bus_quiet_s |=> int_pad_oe)
    else $error("interrupt dropped while bus idle");
  ack_rise_a: assert property ($rose(sda_oe) |-> gap_reg <= 8'h08)
    else $error("data pull started away from a clock fall");
  ack_fall_a: assert property ($fell(sda_oe) |-> gap_reg <= 8'h08)
    else $error("data pull ended away from a clock fall");
endmodule : pti_top_sva

bind pti_top pti_top_sva i_pti_top_sva (.clk(clk), .nrst(nrst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .int_pad_out(int_pad_out),
  .int_pad_oe(int_pad_oe), .meas(meas));

// >>> verification/pti_host_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Two-wire bus host
// ==========================================================================
module pti_host_model
(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt;
    repeat (6) @(posedge clk);
  endtask : wt

  task automatic start;
    sda_low <= 1'b0;
    wt;
    scl <= 1'b1;
    wt;
    sda_low <= 1'b1;
    wt;
    scl <= 1'b0;
    wt;
  endtask : start

  task automatic stop;
    sda_low <= 1'b1;
    wt;
    scl <= 1'b1;
    wt;
    sda_low <= 1'b0;
    wt;
  endtask : stop

  // Data only moves while the clock is low, so it never mimics a start or stop.
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    wt;
    scl <= 1'b1;
    wt;
    r = sda;
    scl <= 1'b0;
    wt;
  endtask : bitx

  task automatic byte_x(input logic [7:0] d, input logic m, output logic [7:0] q,
                        output logic a);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(m, a);
  endtask : byte_x

  task automatic wr(input logic [6:0] dv, input logic [7:0] a, input logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic n0;
    logic n1;
    logic n2;
    start;
    byte_x({dv, 1'b0}, 1'b1, q, n0);
    byte_x(a, 1'b1, q, n1);
    byte_x(d, 1'b1, q, n2);
    stop;
    ok = !n0 && !n1 && !n2;
  endtask : wr

  task automatic rd(input logic [6:0] dv, input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic n;
    start;
    byte_x({dv, 1'b0}, 1'b1, q, n);
    byte_x(a, 1'b1, q, n);
    start;
    byte_x({dv, 1'b1}, 1'b1, q, n);
    byte_x(8'hff, 1'b1, d, n);
    stop;
  endtask : rd
endmodule : pti_host_model

// >>> verification/pti_top_tb.sv
`timescale 1ns/100ps
module pti_top_tb
  import pti_pkg::*;
;
  localparam logic [6:0] DEV = 7'h13;
  logic clk;
  logic nrst;
  wire sda;
  logic scl;
  logic host_low;
  logic sda_out;
  logic sda_oe;
  logic pad_out;
  logic pad_oe;
  pti_meas_t meas;
  int err_count;
  int checked;
  int m[256];
  int run_hi;
  int run_lo;
  logic ok;
  logic [7:0] rv;
  logic [15:0] lo;
  logic [15:0] hi;

  assign sda = !(host_low || sda_oe);

  initial
  begin
    clk = 1'b0;
    forever
      #10 clk = ~clk;
  end

  pti_top #(.DEV_ADDR(DEV), .CNT_W(8)) i_pti_top (.clk(clk), .nrst(nrst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .int_pad_out(pad_out),
    .int_pad_oe(pad_oe), .meas(meas));
  pti_host_model i_pti_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    i_pti_host_model.wr(DEV, a, d, ok);
    chk("write ack", 16'h0001, {15'h0000, ok});
    if (a == PTI_OFS_FLAGS)
      m[a] = m[a] & ~d;
    else if (a >= 8'h89 && a <= 8'h8f)
      m[a] = d;
  endtask : wreg

  task automatic rreg(input logic [7:0] a);
    i_pti_host_model.rd(DEV, a, rv);
    chk("read data", (a >= 8'h89 && a <= 8'h8f) ? 16'(m[a]) : 16'h0000, {8'h00, rv});
    chk("pad", 16'(m[PTI_OFS_FLAGS] != 0), {15'h0000, pad_oe});
  endtask : rreg

  // Drives one measurement and advances the reference flags.
  task automatic smp(input logic [15:0] v);
    int c;
    c = m[PTI_OFS_INT_CTRL];
    meas <= '{valid: 1'b1, data: v};
    @(posedge clk);
    meas <= '{valid: 1'b0, data: 16'($urandom)};
    @(posedge clk);
    if (c[3])
      m[PTI_OFS_FLAGS] |= 8;
    if (c[1] && !c[0])
    begin
      run_hi = (v > hi) ? run_hi + 1 : 0;
      run_lo = (v < lo) ? run_lo + 1 : 0;
      if (run_hi == (1 << c[7:5]))
      begin
        m[PTI_OFS_FLAGS] |= 1;
        run_hi = 0;
      end
      if (run_lo == (1 << c[7:5]))
      begin
        m[PTI_OFS_FLAGS] |= 2;
        run_lo = 0;
      end
    end
  endtask : smp

  task automatic print_verdict;
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (80000) @(posedge clk);
    err_count++;
    print_verdict;
  end

  initial
  begin
    nrst = 1'b0;
    meas = '0;
    void'($urandom(68));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    for (int a = 8'h88; a <= 8'h90; a++)
      rreg(8'(a));
    lo = 16'($urandom_range(16'h0fff, 16'h0100));
    hi = lo + 16'h1000;
    wreg(8'h8a, lo[15:8]);
    wreg(8'h8b, lo[7:0]);
    wreg(8'h8c, hi[15:8]);
    wreg(8'h8d, hi[7:0]);
    wreg(8'h8f, 8'($urandom));
    wreg(8'h90, 8'($urandom));
    for (int a = 8'h8a; a <= 8'h90; a++)
      rreg(8'(a));
    i_pti_host_model.wr(DEV ^ 7'h01, 8'h8f, 8'h5a, ok);
    chk("foreign ack", 16'h0000, {15'h0000, ok});
    rreg(8'h8f);
    wreg(8'h89, 8'h08);
    smp(lo + 16'h0005);
    rreg(8'h8e);
    wreg(8'h8e, 8'h00);
    rreg(8'h8e);
    wreg(8'h8e, 8'h08);
    rreg(8'h8e);
    wreg(8'h89, 8'h00);
    smp(hi + 16'h0001);
    smp(lo - 16'h0001);
    wreg(8'h89, 8'h03);
    smp(hi + 16'h0001);
    rreg(8'h8e);
    for (int k = 0; k < 8; k++)
    begin
      wreg(8'h89, {3'(k), 5'h02});
      smp(hi);
      repeat ((1 << k) - 1) smp(hi + 16'h0001 + 16'($urandom_range(255)));
      rreg(8'h8e);
      smp(hi + 16'h0001);
      rreg(8'h8e);
      smp(lo - 16'h0001);
      smp(lo);
      repeat (1 << k) smp(lo - 16'h0001 - 16'($urandom_range(255)));
      rreg(8'h8e);
      wreg(8'h8e, 8'h03);
      rreg(8'h8e);
    end
    print_verdict;
  end
endmodule : pti_top_tb
